//--- hw/adci_pkg.sv
// adci_pkg: shared constants and types of the converter host interface
// assumes one 10 MHz system clock and a synchronous active-high reset
package adci_pkg;
  localparam int          RESULT_WIDTH       = 8;
  // conversion step clock divider: system cycles per converter clock tick
  localparam int          CONV_CLK_DIV       = 4;
  // ticks spent on each bit decision
  localparam int          TICKS_PER_BIT      = 2;
  // track/hold is taken on this falling converter clock edge after the strobe
  localparam int          HOLD_EDGE          = 3;
  // rom mode guard window after busy rises, in converter clock periods
  localparam int          ROM_GUARD_TICKS    = 1;
  localparam logic [7:0]  RESULT_RESET       = 8'h00;
  localparam logic [7:0]  SAR_HALF_SCALE     = 8'h80;

  typedef enum logic [1:0] {
    ADCI_IDLE,
    ADCI_WAIT_HOLD,
    ADCI_CONVERT,
    ADCI_STALL
  } adci_state_t;
endpackage : adci_pkg

//--- hw/adci_sar_if.sv
// adci_sar_if: handshake between the control logic and the sar engine
// assumes both ends share the block clock
`timescale 1ns/1ns
interface adci_sar_if;
  logic       start;
  logic       step;
  logic       compare_high;
  logic [7:0] trial;
  logic       done;
  logic [7:0] result;
  modport ctrl (output start, output step, input trial, input done, input result);
  modport engine (input start, input step, input compare_high, output trial,
                  output done, output result);
endinterface : adci_sar_if

//--- hw/adci_sar.sv
// adci_sar: eight-step successive approximation register
// assumes the comparator result is valid whenever step is high
`timescale 1ns/1ns
module adci_sar
  import adci_pkg::*;
(
  input wire logic  clock,
  input wire logic  reset,
  adci_sar_if.engine sar
);
  logic [7:0] trial_bit;

  always_ff @(posedge clock) begin
    if (reset) begin
      sar.trial  <= SAR_HALF_SCALE;
      trial_bit  <= SAR_HALF_SCALE;
      sar.done   <= 1'b0;
      sar.result <= RESULT_RESET;
    end else begin
      sar.done <= 1'b0;
      if (sar.start) begin
        sar.trial <= SAR_HALF_SCALE;
        trial_bit <= SAR_HALF_SCALE;
      end else if (sar.step && trial_bit != 8'h00) begin
        // keep the trial bit only when the input is at or above the dac level
        if (!sar.compare_high) begin
          sar.trial <= (sar.trial & ~trial_bit) | (trial_bit >> 1);
        end else begin
          sar.trial <= sar.trial | (trial_bit >> 1);
        end
        trial_bit <= trial_bit >> 1;
        if (trial_bit == 8'h01) begin
          sar.done   <= 1'b1;
          sar.result <= sar.compare_high ? sar.trial : (sar.trial & ~trial_bit);
        end
      end
    end
  end
endmodule : adci_sar

//--- hw/adci_top.sv
// adci_top: host read and convert control of an 8-bit sar converter
// assumes host strobes are synchronous to clock; comparator is external
`timescale 1ns/1ns
// Behaviour
// - Results leave on eight three-state outputs, bit 7 the msb and bit 0 the lsb.
// - The read strobe counts only while device select is low.
// - Data outputs are driven only while select and read are both low.
// - In host-started modes a selected read falling edge starts a conversion.
// - Mode low gives continuous conversion, mode high host-started conversion.
// - Busy goes low when a conversion starts and high when it completes.
// - Conversion timing comes from the converter clock, here a divided tick.
// - When busy returns high the new result is loaded into the output latch.
// - In rom mode a read within one converter clock of busy rising starts nothing.
// - In continuous mode a read held at busy rise delays latch and stops converting.
// - In host-started mode the input is held on the third falling converter clock edge after read falls; continuous mode holds it as conversion starts.
module adci_top
  import adci_pkg::*;
#(
  parameter int DIV = CONV_CLK_DIV
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    select_n,
  input  wire logic                    read_n,
  input  wire logic                    mode,
  input  wire logic                    compare_high,
  output logic [RESULT_WIDTH-1:0]      result_bits_out,
  output logic [RESULT_WIDTH-1:0]      result_bits_oe,
  output logic                         busy_n,
  output logic                         hold_sample,
  output logic [RESULT_WIDTH-1:0]      dac_code
);
  adci_sar_if sar ();
  localparam logic [7:0] GUARD_CYCLES = 8'(DIV * ROM_GUARD_TICKS);

  adci_state_t state;
  logic [7:0]  div_count;
  logic        tick;
  logic        tick_fall;
  logic        read_prev;
  logic        access;
  logic        read_fall;
  logic [2:0]  edge_count;
  logic [2:0]  step_count;
  logic [7:0]  guard_count;
  logic [7:0]  latch_data;
  logic [7:0]  pending;
  logic        pending_valid;

  // divider terminal compare, shared by both tick phases
  function automatic logic div_hit(input logic [7:0] count, input int limit);
    return count == 8'(limit);
  endfunction : div_hit

  // last converter tick of one bit period
  function automatic logic step_last(input logic [2:0] count);
    return count == 3'(TICKS_PER_BIT - 1);
  endfunction : step_last

  assign access            = !select_n && !read_n;
  assign read_fall         = access && !read_prev;
  assign sar.compare_high  = compare_high;

  adci_sar u_sar (
    .clock (clock),
    .reset (reset),
    .sar   (sar)
  );

  // converter clock tick
  // tick_fall sits half a period after tick and stands in for the falling edge
  always_ff @(posedge clock) begin
    if (reset) begin
      div_count <= 8'h00;
      tick      <= 1'b0;
      tick_fall <= 1'b0;
    end else begin
      tick      <= div_hit(div_count, DIV - 1);
      tick_fall <= div_hit(div_count, DIV / 2 - 1);
      div_count <= div_hit(div_count, DIV - 1) ? 8'h00 : div_count + 8'h01;
    end
  end

  // select gates read
  // resets to the idle level of access, so no false edge follows reset
  always_ff @(posedge clock) begin
    if (reset) begin
      read_prev <= 1'b0;
    end else begin
      read_prev <= access;
    end
  end

  // guard after busy rises
  // counted in system cycles so the window spans a whole converter period
  always_ff @(posedge clock) begin
    if (reset) begin
      guard_count <= 8'h00;
    end else if (sar.done) begin
      guard_count <= GUARD_CYCLES;
    end else if (guard_count != 8'h00) begin
      guard_count <= guard_count - 8'h01;
    end
  end

  // conversion sequencing
  always_ff @(posedge clock) begin
    if (reset) begin
      state       <= ADCI_IDLE;
      busy_n      <= 1'b1;
      hold_sample <= 1'b0;
      edge_count  <= 3'h0;
      step_count  <= 3'h0;
      sar.start   <= 1'b0;
      sar.step    <= 1'b0;
    end else begin
      sar.start <= 1'b0;
      sar.step  <= 1'b0;
      case (state)
        ADCI_IDLE: begin
          if (!mode) begin
            if (!access) begin
              state       <= ADCI_CONVERT;
              busy_n      <= 1'b0;
              sar.start   <= 1'b1;
              hold_sample <= 1'b1;
              step_count  <= 3'h0;
            end
          end else if (read_fall && guard_count == 8'h00) begin
            state       <= ADCI_WAIT_HOLD;
            busy_n      <= 1'b0;
            hold_sample <= 1'b0;
            edge_count  <= 3'h0;
            sar.start   <= 1'b1;
          end
        end
        ADCI_WAIT_HOLD: begin
          if (tick_fall) begin
            if (edge_count == 3'(HOLD_EDGE - 1)) begin
              hold_sample <= 1'b1;
              state       <= ADCI_CONVERT;
              step_count  <= 3'h0;
            end
            edge_count <= edge_count + 3'h1;
          end
        end
        ADCI_CONVERT: begin
          if (tick) begin
            step_count <= step_last(step_count) ? 3'h0 : step_count + 3'h1;
            sar.step   <= step_last(step_count);
          end
          if (sar.done) begin
            busy_n      <= 1'b1;
            hold_sample <= 1'b0;
            state       <= (!mode && access) ? ADCI_STALL : ADCI_IDLE;
          end
        end
        ADCI_STALL: begin
          // resume once the read is released
          if (!access) begin
            state <= ADCI_IDLE;
          end
        end
        default: state <= ADCI_IDLE;
      endcase
    end
  end

  // latch on busy rise, deferred while a continuous read is held
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_data    <= RESULT_RESET;
      pending       <= RESULT_RESET;
      pending_valid <= 1'b0;
    end else if (sar.done) begin
      if (!mode && access) begin
        pending       <= sar.result;
        pending_valid <= 1'b1;
      end else begin
        latch_data <= sar.result;
      end
    end else if (pending_valid && !access) begin
      latch_data    <= pending;
      pending_valid <= 1'b0;
    end
  end

  // latched byte, bit 7 the msb
  always_ff @(posedge clock) begin
    if (reset) begin
      result_bits_out <= RESULT_RESET;
    end else begin
      result_bits_out <= latch_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      result_bits_oe <= 8'h00;
    end else begin
      result_bits_oe <= access ? 8'hFF : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dac_code <= SAR_HALF_SCALE;
    end else begin
      dac_code <= sar.trial;
    end
  end
endmodule : adci_top

//--- testbench/adci_top_chk.sv
// adci_top_chk: port-level assertions of the converter host interface
// assumes binding to every adci_top, one clock and a sync reset
`timescale 1ns/1ns
module adci_top_chk
  import adci_pkg::*;
#(
  parameter int DIV = CONV_CLK_DIV
) (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       select_n,
  input wire logic       read_n,
  input wire logic       mode,
  input wire logic [7:0] result_bits_out,
  input wire logic [7:0] result_bits_oe,
  input wire logic       busy_n,
  input wire logic       hold_sample
);
  // hold lands between the second and third converter period after the start
  localparam int HOLD_PRE = 2 * DIV;
  localparam int HOLD_LO  = 2 * DIV + 1;
  localparam int HOLD_HI  = 3 * DIV;
  int   low_cnt;
  logic access;
  assign access = !select_n && !read_n;
  // low_cnt counts busy-low cycles; the bounds allow for hold delay slack
  always_ff @(posedge clock) begin
    if (reset || busy_n) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_oe_tracks_access: assert property (
    !$past(reset) |-> (result_bits_oe == 8'hFF) == $past(access))
    else $error("oe does not follow access");
  a_oe_whole_byte: assert property (
    result_bits_oe == 8'hFF || result_bits_oe == 8'h00)
    else $error("oe is split");
  a_busy_needs_read: assert property (
    mode && $fell(busy_n) |-> $past(access))
    else $error("busy fell without a selected read");
  a_out_held_busy: assert property (
    !busy_n && $past(busy_n) == 0 && $past(busy_n, 2) == 0 |-> $stable(result_bits_out))
    else $error("output latch moved during conversion");
  a_stall_on_read: assert property (
    (!mode && $rose(busy_n) && access && $past(access)) ##1 access [*3] |-> busy_n)
    else $error("conversion went on during held read");
  a_guard_no_start: assert property (
    (mode && $rose(busy_n)) ##1 access |=> busy_n [*2])
    else $error("read in guard window started a conversion");
  a_conv_min_len: assert property (
    $rose(busy_n) |-> low_cnt >= 16 * DIV - 2)
    else $error("conversion too short");
  a_conv_max_len: assert property (
    $rose(busy_n) |-> low_cnt <= 20 * DIV + 8)
    else $error("conversion too long");
  a_hold_not_early: assert property (
    mode && $fell(busy_n) |-> ##HOLD_PRE !hold_sample)
    else $error("input held before the third falling edge");
  a_hold_third_fall: assert property (
    mode && $fell(busy_n) |-> ##[HOLD_LO:HOLD_HI] hold_sample)
    else $error("input not held by the third falling edge");
  c_guard_read: cover property ((mode && $rose(busy_n)) ##1 access);
  c_stall: cover property (!mode && $rose(busy_n) && access);
  c_conv_done: cover property ($rose(busy_n));
  c_hold_taken: cover property (mode && $rose(hold_sample));
endmodule : adci_top_chk

bind adci_top adci_top_chk #(.DIV(DIV)) u_chk (
  .clock           (clock),
  .reset           (reset),
  .select_n        (select_n),
  .read_n          (read_n),
  .mode            (mode),
  .result_bits_out (result_bits_out),
  .result_bits_oe  (result_bits_oe),
  .busy_n          (busy_n),
  .hold_sample     (hold_sample)
);

//--- testbench/adci_analog_model.sv
// adci_analog_model: analog source and comparator beside the converter
// assumes an ideal comparator with no offset or delay
`timescale 1ns/1ns
module adci_analog_model (
  input  wire logic [7:0] dac_code,
  input  wire logic [7:0] level,
  output logic            compare_high
);
  assign compare_high = (level >= dac_code);
endmodule : adci_analog_model

//--- testbench/test_adc_host_read_convert_interface.sv
// test_adc_host_read_convert_interface: self-checking bench of adci_top
// assumes adci_analog_model stands in for the analog side
`timescale 1ns/1ns
module test_adc_host_read_convert_interface;
  import adci_pkg::*;
  localparam int D = 4;
  logic       clock    = 1'b0;
  logic       reset    = 1'b1;
  logic       select_n = 1'b1;
  logic       read_n   = 1'b1;
  logic       mode     = 1'b1;
  logic [7:0] level    = 8'h00;
  logic       compare_high;
  logic [7:0] out;
  logic [7:0] oe;
  logic       busy_n;
  logic [7:0] dac_code;
  logic       hold;
  logic [7:0] prev;
  int         n_fail   = 0;
  int         n_checks = 0;
  always #50 clock = ~clock;
  adci_top #(.DIV(D)) u_dut (.clock(clock), .reset(reset), .select_n(select_n),
    .read_n(read_n), .mode(mode), .compare_high(compare_high), .result_bits_out(out),
    .result_bits_oe(oe), .busy_n(busy_n), .hold_sample(hold), .dac_code(dac_code));
  adci_analog_model u_ana (.dac_code(dac_code), .level(level), .compare_high(compare_high));
  // reference sar: keep each trial bit the input still reaches
  function automatic logic [7:0] sar_ref(input logic [7:0] v);
    int code;
    code = 0;
    for (int b = 7; b >= 0; b--) begin
      if (int'(v) >= (code | (1 << b))) code = code | (1 << b);
    end
    return 8'(code);
  endfunction : sar_ref
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask : tick
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic check_busy(input logic exp);
    check("busy_n", {7'h00, exp}, {7'h00, busy_n});
  endtask : check_busy
  task automatic check_hold(input logic exp);
    check("hold_sample", {7'h00, exp}, {7'h00, hold});
  endtask : check_hold
  // bounded wait, so a stuck busy shows as a mismatch, not a hang
  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 400 && busy_n !== lvl; k++) tick(1);
    check_busy(lvl);
  endtask : wait_busy
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    #(100 * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h33F7));
    tick(20);
    reset = 1'b0;
    tick(1);
    check_busy(1'b1);
    check("oe", 8'h00, oe);
    check_hold(1'b0);
    read_n = 1'b0;
    tick(6);
    check_busy(1'b1);
    check("oe", 8'h00, oe);
    for (int i = 0; i < 6; i++) begin
      level = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      select_n = 1'b0;
      tick(2);
      check("oe", 8'hFF, oe);
      check_busy(1'b0);
      check_hold(1'b0);
      select_n = 1'b1;
      tick(3 * D);
      check_hold(1'b1);
      wait_busy(1'b1);
      select_n = 1'b0;
      tick(3);
      check_busy(1'b1);
      check("out", sar_ref(level), out);
      select_n = 1'b1;
      tick(2);
      check("oe", 8'h00, oe);
      tick(D);
    end
    mode = 1'b0;
    level = 8'($urandom);
    wait_busy(1'b0);
    wait_busy(1'b1);
    prev = level;
    level = ~prev;
    wait_busy(1'b0);
    select_n = 1'b0;
    wait_busy(1'b1);
    tick(8);
    check_busy(1'b1);
    check("out", sar_ref(prev), out);
    select_n = 1'b1;
    wait_busy(1'b0);
    check("out", sar_ref(level), out);
    end_of_test();
  end
endmodule : test_adc_host_read_convert_interface
